// >>> tes_edge_setup.sv
// Triangle edge setup register bank with a scan line edge walker.
// Assumes a one-cycle strobe register port on core_clk; read data one
// cycle after the read strobe. Attribute and command logic live elsewhere.
`timescale 1ns/1ps
`default_nettype none
module tes_edge_setup
    import tes_pkg::*;
(
    input wire logic core_clk, // 20 MHz core clock
    input wire logic sys_rst, // Async reset, active high
    input wire tes_pkg::tes_bus_req_t bus_req, // Strobes, address, data
    output logic [tes_pkg::TES_DATA_W-1:0] rd_data, // Read data
    output logic walk_busy, // Edge walk in progress
    output logic line_valid, // One pulse per walked line
    output logic left_to_right, // Rendering direction
    output logic [tes_pkg::TES_ACC_W-1:0] long_x, // Side 02 edge X
    output logic [tes_pkg::TES_ACC_W-1:0] short_x, // Side 01/12 edge X
    output logic [tes_pkg::TES_ACC_W-1:0] cur_y // Current Y
);
    import tes_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Setup registers
    logic [31:0] b_slope_r, b_slope_nxt;
    logic [31:0] b_end_r, b_end_nxt;
    logic [31:0] a_slope_r, a_slope_nxt;
    logic [31:0] a_end_r, a_end_nxt;
    logic [31:0] l_slope_r, l_slope_nxt;
    logic [31:0] x_init_r, x_init_nxt;
    logic [31:0] y_init_r, y_init_nxt;
    logic [31:0] counts_r, counts_nxt;
    logic [31:0] rd_data_r, rd_data_nxt;
    logic start_walk;
    logic [TES_CNT_W-1:0] cnt_a;
    logic [TES_CNT_W-1:0] cnt_b;

    // Field views of the count register
    assign cnt_b = counts_r[TES_CNT_B_LSB +: TES_CNT_W];
    assign cnt_a = counts_r[TES_CNT_A_LSB +: TES_CNT_W];

    // Write decode; a write of 1 to the walk offset starts a walk
    always_comb begin
        b_slope_nxt = b_slope_r;
        b_end_nxt = b_end_r;
        a_slope_nxt = a_slope_r;
        a_end_nxt = a_end_r;
        l_slope_nxt = l_slope_r;
        x_init_nxt = x_init_r;
        y_init_nxt = y_init_r;
        counts_nxt = counts_r;
        start_walk = 1'b0;
        if (bus_req.wr) begin
            case (bus_req.addr)
                TES_OFF_B_SLOPE: b_slope_nxt = bus_req.wdata;
                TES_OFF_B_END: b_end_nxt = bus_req.wdata;
                TES_OFF_A_SLOPE: a_slope_nxt = bus_req.wdata;
                TES_OFF_A_END: a_end_nxt = bus_req.wdata;
                TES_OFF_L_SLOPE: l_slope_nxt = bus_req.wdata;
                TES_OFF_X_INIT: x_init_nxt = bus_req.wdata;
                TES_OFF_Y_INIT: y_init_nxt = bus_req.wdata;
                TES_OFF_COUNTS: counts_nxt = bus_req.wdata & TES_COUNTS_MASK;
                TES_OFF_WALK: start_walk = bus_req.wdata[0];
                default: ;
            endcase
        end
    end

    // Read mux; unmapped offsets read zero
    always_comb begin
        rd_data_nxt = rd_data_r;
        if (bus_req.rd) begin
            case (bus_req.addr)
                TES_OFF_B_SLOPE: rd_data_nxt = b_slope_r;
                TES_OFF_B_END: rd_data_nxt = b_end_r;
                TES_OFF_A_SLOPE: rd_data_nxt = a_slope_r;
                TES_OFF_A_END: rd_data_nxt = a_end_r;
                TES_OFF_L_SLOPE: rd_data_nxt = l_slope_r;
                TES_OFF_X_INIT: rd_data_nxt = x_init_r;
                TES_OFF_Y_INIT: rd_data_nxt = y_init_r;
                TES_OFF_COUNTS: rd_data_nxt = counts_r;
                TES_OFF_STAT: rd_data_nxt = {30'h0, left_to_right, walk_busy};
                TES_OFF_XL: rd_data_nxt = long_x;
                TES_OFF_XS: rd_data_nxt = short_x;
                TES_OFF_YACC: rd_data_nxt = cur_y;
                default: rd_data_nxt = 32'h00000000;
            endcase
        end
    end

    // Register bank
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            b_slope_r <= TES_REG_RST;
            b_end_r <= TES_REG_RST;
            a_slope_r <= TES_REG_RST;
            a_end_r <= TES_REG_RST;
            l_slope_r <= TES_REG_RST;
            x_init_r <= TES_REG_RST;
            y_init_r <= TES_REG_RST;
            counts_r <= TES_REG_RST;
            rd_data_r <= TES_REG_RST;
        end else begin
            b_slope_r <= b_slope_nxt;
            b_end_r <= b_end_nxt;
            a_slope_r <= a_slope_nxt;
            a_end_r <= a_end_nxt;
            l_slope_r <= l_slope_nxt;
            x_init_r <= x_init_nxt;
            y_init_r <= y_init_nxt;
            counts_r <= counts_nxt;
            rd_data_r <= rd_data_nxt;
        end
    end

    assign rd_data = rd_data_r;

    ////////////////////////////////////////////////////////////////////////
    // Edge walker
    tes_state_t state_r, state_nxt;
    logic [TES_CNT_W-1:0] left_r, left_nxt;
    logic [31:0] y_r, y_nxt;
    logic line_r, line_nxt;
    logic dir_r, dir_nxt;
    logic acc_load;
    logic acc_step;
    logic short_load;
    logic [31:0] short_slope;
    logic busy_r, busy_nxt;

    // Walk sequence: side 01 lines first, then side 12 lines
    always_comb begin
        state_nxt = state_r;
        left_nxt = left_r;
        y_nxt = y_r;
        line_nxt = 1'b0;
        dir_nxt = dir_r;
        acc_load = 1'b0;
        acc_step = 1'b0;
        short_load = 1'b0;
        case (state_r)
            TES_IDLE: begin
                if (start_walk && (cnt_a != '0 || cnt_b != '0)) begin
                    acc_load = 1'b1;
                    short_load = 1'b1;
                    y_nxt = y_init_r;
                    dir_nxt = counts_r[TES_DIR_BIT];
                    if (cnt_a != '0) begin
                        state_nxt = TES_SIDE_A;
                        left_nxt = cnt_a;
                    end else begin
                        state_nxt = TES_SIDE_B;
                        left_nxt = cnt_b;
                    end
                end
            end
            TES_SIDE_A, TES_SIDE_B: begin
                acc_step = 1'b1;
                line_nxt = 1'b1;
                y_nxt = 32'(y_r + TES_Y_STEP);
                left_nxt = TES_CNT_W'(left_r - 1'b1);
                if (left_r == TES_CNT_W'(1)) begin
                    if (state_r == TES_SIDE_A && cnt_b != '0) begin
                        state_nxt = TES_SIDE_B;
                        left_nxt = cnt_b;
                    end else begin
                        state_nxt = TES_IDLE;
                    end
                end
            end
            default: state_nxt = TES_IDLE;
        endcase
        // Busy is registered so the output comes straight from a flop
        busy_nxt = (state_nxt != TES_IDLE);
    end

    // Walker registers
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= TES_IDLE;
            left_r <= '0;
            y_r <= TES_REG_RST;
            line_r <= 1'b0;
            dir_r <= 1'b0;
            busy_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            left_r <= left_nxt;
            y_r <= y_nxt;
            line_r <= line_nxt;
            dir_r <= dir_nxt;
            busy_r <= busy_nxt;
        end
    end

    // Short edge uses the slope of the side being walked
    assign short_slope = (state_r == TES_SIDE_B) ? b_slope_r : a_slope_r;

    // Long edge accumulator, side 02
    tes_edge_acc #(.W(TES_ACC_W)) u_long_acc (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(acc_load),
        .start(x_init_r),
        .step(acc_step),
        .slope(l_slope_r),
        .acc(long_x)
    );

    // Short edge accumulator, side 01 then 12
    tes_edge_acc #(.W(TES_ACC_W)) u_short_acc (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(short_load),
        .start(x_init_r),
        .step(acc_step),
        .slope(short_slope),
        .acc(short_x)
    );

    assign walk_busy = busy_r;
    assign line_valid = line_r;
    assign left_to_right = dir_r;
    assign cur_y = y_r;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    sequence walk_go_s;
        start_walk && state_r == TES_IDLE && (cnt_a != '0 || cnt_b != '0);
    endsequence

    no_empty_walk_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (start_walk && cnt_a == '0 && cnt_b == '0 && state_r == TES_IDLE)
        |=> state_r == TES_IDLE)
        else $error("walk started with zero line counts");

    walk_start_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_go_s |=> walk_busy && long_x == $past(x_init_r)
        && short_x == $past(x_init_r))
        else $error("walk did not load initial X");

    y_load_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_go_s |=> cur_y == $past(y_init_r))
        else $error("walk did not load initial Y");

    dir_latch_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_go_s |=> left_to_right == $past(counts_r[31]))
        else $error("direction not taken from bit 31");

    side_a_first_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (walk_go_s and cnt_a != '0) |=> state_r == TES_SIDE_A)
        else $error("side 01 not walked first");

    side_b_only_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (walk_go_s and cnt_a == '0) |=> state_r == TES_SIDE_B)
        else $error("side 12 not walked");

    long_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        walk_busy |=> long_x == 32'($past(long_x) + $past(l_slope_r)))
        else $error("long edge step wrong");

    short_a_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == TES_SIDE_A
        |=> short_x == 32'($past(short_x) + $past(a_slope_r)))
        else $error("side 01 step wrong");

    short_b_step_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        state_r == TES_SIDE_B
        |=> short_x == 32'($past(short_x) + $past(b_slope_r)))
        else $error("side 12 step wrong");

    count_rsvd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (counts_r & ~TES_COUNTS_MASK) == 32'h00000000)
        else $error("reserved count bits set");

    end_hold_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        !(bus_req.wr && bus_req.addr == TES_OFF_A_END)
        |=> a_end_r == $past(a_end_r))
        else $error("side 01 end changed without write");

    end_b_rd_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        (bus_req.rd && bus_req.addr == TES_OFF_B_END)
        |=> rd_data == $past(b_end_r))
        else $error("side 12 end read wrong");

    line_pulse_a: assert property (@(posedge core_clk) disable iff (sys_rst)
        line_valid == $past(walk_busy))
        else $error("line pulse does not follow a busy cycle");
endmodule : tes_edge_setup
`default_nettype wire

// >>> tes_pkg.sv
// Package for the triangle edge setup block: offsets, fields, types.
// Assumes a 32-bit register port with byte addresses.
package tes_pkg;
    localparam int unsigned TES_DATA_W = 32;
    localparam int unsigned TES_ADDR_W = 16;
    localparam int unsigned TES_ACC_W = 32;
    // Register offsets
    localparam logic [15:0] TES_OFF_B_SLOPE = 16'hB560;
    localparam logic [15:0] TES_OFF_B_END = 16'hB564;
    localparam logic [15:0] TES_OFF_A_SLOPE = 16'hB568;
    localparam logic [15:0] TES_OFF_A_END = 16'hB56C;
    localparam logic [15:0] TES_OFF_L_SLOPE = 16'hB570;
    localparam logic [15:0] TES_OFF_X_INIT = 16'hB574;
    localparam logic [15:0] TES_OFF_Y_INIT = 16'hB578;
    localparam logic [15:0] TES_OFF_COUNTS = 16'hB57C;
    localparam logic [15:0] TES_OFF_WALK = 16'hB580;
    localparam logic [15:0] TES_OFF_STAT = 16'hB584;
    localparam logic [15:0] TES_OFF_XL = 16'hB588;
    localparam logic [15:0] TES_OFF_XS = 16'hB58C;
    localparam logic [15:0] TES_OFF_YACC = 16'hB590;
    // Count register fields
    localparam int unsigned TES_CNT_W = 11;
    localparam int unsigned TES_CNT_B_LSB = 0;
    localparam int unsigned TES_CNT_A_LSB = 16;
    localparam int unsigned TES_DIR_BIT = 31;
    // Writable bits of the count register; reserved bits read zero
    localparam logic [31:0] TES_COUNTS_MASK = 32'h87FF07FF;
    // Y step of one scan line in S11.20
    localparam logic [31:0] TES_Y_STEP = 32'h00100000;
    // Reset value of the setup registers (contents undefined to software)
    localparam logic [31:0] TES_REG_RST = 32'h00000000;

    typedef enum logic [1:0] {
        TES_IDLE = 2'b00,
        TES_SIDE_A = 2'b01,
        TES_SIDE_B = 2'b10
    } tes_state_t;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [TES_ADDR_W-1:0] addr;
        logic [TES_DATA_W-1:0] wdata;
    } tes_bus_req_t;
endpackage : tes_pkg

// >>> tes_edge_acc.sv
// One X edge accumulator in S11.20: load, then add a slope per step.
// Assumes load and step never come in the same cycle as each other.
`timescale 1ns/1ps
`default_nettype none
module tes_edge_acc #(
    parameter int unsigned W = 32
) (
    input wire logic core_clk, // Clock
    input wire logic sys_rst, // Async reset, high
    input wire logic load, // Load start value
    input wire logic [W-1:0] start, // Start value
    input wire logic step, // Add slope
    input wire logic [W-1:0] slope, // Signed slope
    output logic [W-1:0] acc // Accumulated value
);
    logic [W-1:0] acc_r;
    logic [W-1:0] acc_nxt;

    // Next value: load wins, else one signed add
    always_comb begin
        acc_nxt = acc_r;
        if (load) begin
            acc_nxt = start;
        end else if (step) begin
            acc_nxt = W'(acc_r + slope);
        end
    end

    // Register
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            acc_r <= '0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign acc = acc_r;
endmodule : tes_edge_acc
`default_nettype wire

// >>> tes_host.sv
// Host model that programs the edge setup bank over the register port.
// Assumes one-cycle strobes and read data in the cycle after the strobe.
`timescale 1ns/1ps
`default_nettype none
module tes_host (
    input wire logic core_clk, // Core clock
    output var tes_pkg::tes_bus_req_t bus_req, // Strobes, address, data
    input wire logic [tes_pkg::TES_DATA_W-1:0] rd_data // Read data
);
    import tes_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Idle bus at time zero
    initial begin
        bus_req = '0;
    end

    // One-cycle write; released lines carry the inverse, not stale values
    task automatic write_reg(input logic [15:0] a, input logic [31:0] d);
        @(posedge core_clk);
        bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        bus_req.addr <= ~a;
        bus_req.wdata <= ~d;
    endtask : write_reg

    // One-cycle read; data taken in the cycle after the strobe only
    task automatic read_reg(input logic [15:0] a, output logic [31:0] d);
        @(posedge core_clk);
        bus_req.rd <= 1'b1;
        bus_req.addr <= a;
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        bus_req.addr <= ~a;
        #1;
        d = rd_data;
    endtask : read_reg

    // Loads every setup register before a draw
    task automatic load_setup(input logic [31:0] sb, eb, sa, ea, sl, xi,
                              input logic [31:0] yi, cnt);
        write_reg(TES_OFF_B_SLOPE, sb);
        write_reg(TES_OFF_B_END, {1'b0, eb[30:0]});
        write_reg(TES_OFF_A_SLOPE, sa);
        write_reg(TES_OFF_A_END, {1'b0, ea[30:0]});
        write_reg(TES_OFF_L_SLOPE, sl);
        write_reg(TES_OFF_X_INIT, {1'b0, xi[30:0]});
        write_reg(TES_OFF_Y_INIT, {1'b0, yi[30:0]});
        // Caller picks a direction from the tallest side
        write_reg(TES_OFF_COUNTS, cnt);
    endtask : load_setup
endmodule : tes_host
`default_nettype wire

// >>> tb_tes.sv
// Self-checking bench for the edge setup bank and its edge walker.
// Assumes tes_host drives the register port on the rising edge.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import tes_pkg::*;
    localparam logic [31:0] XI = 32'h00A80000;
    localparam logic [31:0] YI = 32'h00300000;
    localparam logic [31:0] SA = 32'h00180000;
    localparam logic [31:0] SB = 32'hFFF80000;
    localparam logic [31:0] SL = 32'h00040000;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    tes_bus_req_t bus_req;
    logic [31:0] rd_data, long_x, short_x, cur_y, v;
    logic walk_busy, line_valid, left_to_right;
    int error_cnt = 0;
    int n_tests = 0;
    logic [15:0] offs [8] = '{TES_OFF_B_SLOPE, TES_OFF_B_END, TES_OFF_A_SLOPE,
        TES_OFF_A_END, TES_OFF_L_SLOPE, TES_OFF_X_INIT, TES_OFF_Y_INIT,
        TES_OFF_COUNTS};
    logic [31:0] vals [8] = '{32'hFFF80001, 32'h0123ABCD, 32'h00080010,
        32'h7FFFFFFF, 32'h80000000, 32'h00A80000, 32'h00300000, 32'hFFFFFFFF};

    ////////////////////////////////////////////////////////////////////////
    // Clock at 20 MHz
    always #25 core_clk = ~core_clk;

    tes_host host (.core_clk(core_clk), .bus_req(bus_req), .rd_data(rd_data));
    tes_edge_setup dut (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus_req(bus_req), .rd_data(rd_data), .walk_busy(walk_busy),
        .line_valid(line_valid), .left_to_right(left_to_right),
        .long_x(long_x), .short_x(short_x), .cur_y(cur_y));

    ////////////////////////////////////////////////////////////////////////
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask : check

    // Print counts and verdict, then stop
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // Start a walk and follow each line, expecting one pulse per cycle
    task automatic run_walk(input int na, input int nb);
        int k;
        int n;
        logic [31:0] es;
        host.write_reg(TES_OFF_WALK, 32'h00000001);
        #1;
        check(32'(walk_busy), 32'h1);
        check(long_x, XI);
        check(short_x, XI);
        check(cur_y, YI);
        es = XI;
        for (k = 1; k <= na + nb; k++) begin
            n = 0;
            line_valid_wait: while (n < 4) begin
                @(posedge core_clk);
                #1;
                n++;
                if (line_valid === 1'b1) break;
            end
            if (line_valid !== 1'b1) begin
                error_cnt++;
                report_and_stop();
            end
            check(32'(n), 32'h1);
            es = es + ((k <= na) ? SA : SB);
            check(short_x, es);
            check(long_x, XI + 32'(k) * SL);
            check(cur_y, YI + 32'(k) * TES_Y_STEP);
        end
        check(32'(walk_busy), 32'h0);
    endtask : run_walk

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        // Register write and read back, reserved count bits read zero
        for (int i = 0; i < 8; i++) host.write_reg(offs[i], vals[i]);
        for (int i = 0; i < 8; i++) begin
            host.read_reg(offs[i], v);
            check(v, (i == 7) ? TES_COUNTS_MASK : vals[i]);
        end
        host.write_reg(16'hB5A0, 32'h5A5A5A5A);
        host.read_reg(16'hB5A0, v);
        check(v, 32'h0);
        $display("test registers done");
        // Side 01 then side 12, left to right
        host.load_setup(SB, 32'h00500000, SA, 32'h00200000, SL, XI, YI,
                        32'h80010002);
        run_walk(1, 2);
        check(32'(left_to_right), 32'h1);
        // Status and accumulator views hold their end values when idle
        host.read_reg(TES_OFF_STAT, v);
        check(v, 32'h00000002);
        host.read_reg(TES_OFF_XL, v);
        check(v, XI + 32'd3 * SL);
        host.read_reg(TES_OFF_XS, v);
        check(v, XI + SA + 32'd2 * SB);
        host.read_reg(TES_OFF_YACC, v);
        check(v, YI + 32'd3 * TES_Y_STEP);
        $display("test walk both sides done");
        // Side 12 only, right to left
        host.write_reg(TES_OFF_COUNTS, 32'h00000001);
        run_walk(0, 1);
        check(32'(left_to_right), 32'h0);
        $display("test walk one side done");
        // Both counts zero: start is ignored
        host.write_reg(TES_OFF_COUNTS, 32'h80000000);
        host.write_reg(TES_OFF_WALK, 32'h00000001);
        repeat (3) begin
            #1;
            check(32'(walk_busy), 32'h0);
            check(32'(line_valid), 32'h0);
            @(posedge core_clk);
        end
        $display("test zero counts done");
        report_and_stop();
    end
endmodule : testbench
`default_nettype wire
